// File: rtl/ovh_mon_pkg.sv
// constants and carriers for the transport overhead monitor
package ovh_mon_pkg;
  localparam int NUM_LVL = 8;
  localparam int LVL_W = 3;
  localparam logic [2:0] LVL_SM = 3'h0;
  localparam logic [2:0] LVL_PM = 3'h7;
  localparam int TTI_LEN = 64;
  localparam int TTI_AW = 6;
  localparam int TTI_SAPI_OFS = 0;
  localparam int TTI_DAPI_OFS = 16;
  localparam int TTI_OPER_OFS = 32;
  localparam int TTI_OPER_LEN = 32;
  localparam int FTFL_FIELD_LEN = 128;
  localparam int FTFL_CC_LEN = 3;
  localparam int FTFL_NSC_MAX = 6;
  localparam int FTFL_OPID_LEN = FTFL_CC_LEN + FTFL_NSC_MAX;
  localparam logic [6:0] FTFL_FIF_OFS = 7'h00;
  localparam logic [6:0] FTFL_OPID_OFS = 7'h01;
  localparam logic [7:0] MFAS_RST = 8'hff;
  localparam logic [7:0] MFAS_MAX = 8'hff;
  localparam logic [3:0] BEI_MAX = 4'h8;
  localparam logic [3:0] BIAE_CODE = 4'hb;
  localparam int BEI_HI = 7;
  localparam int BEI_LO = 4;
  localparam int BDI_BIT = 3;
  localparam int IAE_BIT = 2;
  localparam int STAT_HI = 2;
  localparam int STAT_LO = 0;
  localparam logic [1:0] SM_RES_VAL = 2'h0;
  localparam logic [2:0] STAT_NO_SRC = 3'h0;
  localparam logic [2:0] STAT_NORMAL = 3'h1;
  localparam logic [2:0] STAT_IAE = 3'h2;
  localparam logic [2:0] STAT_RES_A = 3'h3;
  localparam logic [2:0] STAT_RES_B = 3'h4;
  localparam logic [2:0] STAT_LCK = 3'h5;
  localparam logic [2:0] STAT_OCI = 3'h6;
  localparam logic [2:0] STAT_AIS = 3'h7;
  localparam logic [7:0] FIF_NONE = 8'h00;
  localparam logic [7:0] FIF_SF = 8'h01;
  localparam logic [7:0] FIF_SD = 8'h02;

  typedef enum logic [1:0] {FAULT_NONE, FAULT_SF, FAULT_SD} fault_e;

  typedef struct packed {
    logic [7:0] tti;
    logic [7:0] bip;
    logic [7:0] stat;
  } ovh_s;

  typedef struct packed {
    logic [3:0] bei;
    logic biae;
    logic bdi;
    logic iae;
    logic [2:0] stat;
    logic stat_rsvd;
  } rx_stat_s;
endpackage : ovh_mon_pkg

// File: rtl/tti_lane_ram.sv
// multi-lane byte memory for trail trace identifiers
`timescale 1ns/100ps
`default_nettype none
module tti_lane_ram
  import ovh_mon_pkg::*;
#(
  parameter int LANES = NUM_LVL,
  parameter int DEPTH = TTI_LEN,
  parameter int AW = TTI_AW
)
(
  input wire logic core_clk_in, // frame clock
  input wire logic [LANES-1:0] wr_en_in, // per-lane write strobe
  input wire logic [AW-1:0] wr_addr_in, // write byte index
  input wire logic [LANES-1:0][7:0] wr_data_in, // per-lane data
  input wire logic [AW-1:0] rd_addr_in, // read byte index
  output logic [LANES-1:0][7:0] rd_data_out // registered read data
);
  logic [7:0] mem [LANES][DEPTH];

  if (DEPTH != (1 << AW))
  begin : g_depth_check
    $error("tti_lane_ram: depth must be two to the address width");
  end

  always_ff @(posedge core_clk_in)
  begin
    for (int l = 0; l < LANES; l++)
    begin
      if (wr_en_in[l])
        mem[l][wr_addr_in] <= wr_data_in[l];
      rd_data_out[l] <= mem[l][rd_addr_in];
    end
  end
endmodule : tti_lane_ram
`default_nettype wire

// File: rtl/otn_path_monitor_overhead.sv
// monitoring overhead source and sink for section, tandem and path levels
//
// Function
// - each level sends a 64-byte trace, a byte per frame, multiframe aligned
// - trace holds source id, destination id and 32 operator bytes
// - every level uses trace byte, BIP-8 byte and a status byte
// - section/tandem bits 1-4 carry 0..8 errors; 1011 is BIAE; others zero
// - bit 5 reports backward defect while signal fail is to be sent
// - section bit 6 reports incoming alignment error
// - section bits 7-8 are reserved with no function
// - tandem and path bits 6-8 form a three-bit status field
// - tandem status codes: no source, in use, in use with IAE, LCK, OCI, AIS
// - fault message has forward and backward fields of 128 bytes each
// - fault byte: 00 none, 01 signal fail, 02 degrade, rest reserved
// - operator id holds 3-char country code then 1-6 char segment code
// - path bits 1-4 carry only error count, no BIAE code
// - path sink counts errored parity blocks and returns count backward
// - path status: 001 normal, 101 LCK, 110 OCI, 111 AIS, rest reserved
// - multiframe counter runs 0 to 255 and wraps, one step per frame
`timescale 1ns/100ps
`default_nettype none
module otn_path_monitor_overhead
  import ovh_mon_pkg::*;
(
  input wire logic core_clk_in, // frame clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic frame_start_in, // one-cycle frame boundary pulse
  input wire logic [7:0] rx_mfas_in, // received multiframe byte
  input wire ovh_s [NUM_LVL-1:0] rx_ovh_in, // received overhead per level
  input wire logic [NUM_LVL-1:0][7:0] rx_bip_calc_in, // local parity, rx
  input wire logic [7:0] rx_ftfl_in, // received fault message byte
  input wire logic [NUM_LVL-1:0][7:0] tx_bip_calc_in, // parity to send
  input wire logic [NUM_LVL-1:0] tx_sf_in, // signal fail to report back
  input wire logic tx_iae_in, // section alignment error to report
  input wire logic [NUM_LVL-1:0][2:0] tx_stat_in, // status code to send
  input wire fault_e tx_fwd_fault_in, // forward fault type
  input wire fault_e tx_bwd_fault_in, // backward fault type
  input wire logic [FTFL_OPID_LEN-1:0][7:0] tx_opid_in, // operator id chars
  input wire logic tti_wr_en_in, // trace write strobe
  input wire logic [LVL_W-1:0] tti_wr_lvl_in, // trace level to write
  input wire logic [TTI_AW-1:0] tti_wr_addr_in, // trace byte index
  input wire logic [7:0] tti_wr_data_in, // trace byte value
  input wire logic [TTI_AW-1:0] tti_rd_addr_in, // captured trace index
  output logic [7:0] mfas_out, // multiframe count of current frame
  output var ovh_s [NUM_LVL-1:0] tx_ovh_out, // overhead to send per level
  output logic [7:0] tx_ftfl_out, // fault message byte to send
  output var rx_stat_s [NUM_LVL-1:0] rx_stat_out, // decoded status per level
  output logic [NUM_LVL-1:0][3:0] rx_err_cnt_out, // errored blocks seen
  output logic [NUM_LVL-1:0][7:0] rx_tti_out, // captured trace bytes
  output logic [7:0] rx_fwd_fif_out, // received forward fault byte
  output logic [7:0] rx_bwd_fif_out, // received backward fault byte
  output logic [1:0] rx_fif_rsvd_out // reserved fault code seen, fwd/bwd
);

  // count of errored bit lanes between received and computed parity
  function automatic logic [3:0] bip_errs(input logic [7:0] a,
                                          input logic [7:0] b);
    logic [3:0] n;
    logic [7:0] d;
    n = 4'h0;
    d = a ^ b;
    for (int i = 0; i < 8; i++)
      n = n + {3'h0, d[i]};
    return n;
  endfunction : bip_errs

  // backward error nibble to count
  function automatic logic [3:0] bei_count(input logic [3:0] code);
    return (code <= BEI_MAX) ? code : 4'h0;
  endfunction : bei_count

  // reserved status codes differ between tandem and path levels
  function automatic logic stat_reserved(input logic [LVL_W-1:0] lvl,
                                         input logic [2:0] code);
    logic r;
    r = 1'b0;
    if (lvl == LVL_PM)
      r = !(code == STAT_NORMAL || code == STAT_LCK ||
            code == STAT_OCI || code == STAT_AIS);
    else if (lvl != LVL_SM)
      r = (code == STAT_RES_A || code == STAT_RES_B);
    return r;
  endfunction : stat_reserved

  function automatic logic [7:0] fault_byte(input fault_e f);
    logic [7:0] b;
    unique case (f)
      FAULT_SF: b = FIF_SF;
      FAULT_SD: b = FIF_SD;
      default: b = FIF_NONE;
    endcase
    return b;
  endfunction : fault_byte

  // multiframe counter
  logic [7:0] mfas_r;
  logic [7:0] mfas_nxt;

  always_comb
  begin
    mfas_nxt = mfas_r;
    if (frame_start_in)
      mfas_nxt = (mfas_r == MFAS_MAX) ? 8'h00 : mfas_r + 8'h01;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      mfas_r <= MFAS_RST;
    else
      mfas_r <= mfas_nxt;
  end
  assign mfas_out = mfas_r;

  // transmit trace store, read one frame ahead of its use
  logic [NUM_LVL-1:0] tx_tti_we;
  logic [NUM_LVL-1:0][7:0] tx_tti_wd;
  logic [NUM_LVL-1:0][7:0] tx_tti_q;
  logic [7:0] mfas_ahead;

  assign mfas_ahead = mfas_r + 8'h01;

  always_comb
  begin
    tx_tti_we = '0;
    tx_tti_we[tti_wr_lvl_in] = tti_wr_en_in;
    tx_tti_wd = {NUM_LVL{tti_wr_data_in}};
  end

  tti_lane_ram u_tx_tti (
    .core_clk_in(core_clk_in),
    .wr_en_in(tx_tti_we),
    .wr_addr_in(tti_wr_addr_in),
    .wr_data_in(tx_tti_wd),
    .rd_addr_in(mfas_ahead[TTI_AW-1:0]),
    .rd_data_out(tx_tti_q)
  );

  // receive trace capture at the received multiframe position
  logic [NUM_LVL-1:0][7:0] rx_tti_wd;

  always_comb
  begin
    for (int l = 0; l < NUM_LVL; l++)
      rx_tti_wd[l] = rx_ovh_in[l].tti;
  end

  tti_lane_ram u_rx_tti (
    .core_clk_in(core_clk_in),
    .wr_en_in({NUM_LVL{frame_start_in}}),
    .wr_addr_in(rx_mfas_in[TTI_AW-1:0]),
    .wr_data_in(rx_tti_wd),
    .rd_addr_in(tti_rd_addr_in),
    .rd_data_out(rx_tti_out)
  );

  // sink: decode received status and count parity errors
  rx_stat_s [NUM_LVL-1:0] rx_stat_r;
  rx_stat_s [NUM_LVL-1:0] rx_stat_nxt;
  logic [NUM_LVL-1:0][3:0] err_cnt_r;
  logic [NUM_LVL-1:0][3:0] err_cnt_nxt;

  always_comb
  begin
    rx_stat_nxt = rx_stat_r;
    err_cnt_nxt = err_cnt_r;
    if (frame_start_in)
    begin
      for (int l = 0; l < NUM_LVL; l++)
      begin
        err_cnt_nxt[l] = bip_errs(rx_ovh_in[l].bip,
                                  rx_bip_calc_in[l]);
        rx_stat_nxt[l].bei = bei_count(rx_ovh_in[l].stat[BEI_HI:BEI_LO]);
        rx_stat_nxt[l].biae = (l != LVL_PM) &&
          (rx_ovh_in[l].stat[BEI_HI:BEI_LO] == BIAE_CODE);
        rx_stat_nxt[l].bdi = rx_ovh_in[l].stat[BDI_BIT];
        if (l == LVL_SM)
        begin
          rx_stat_nxt[l].iae = rx_ovh_in[l].stat[IAE_BIT];
          rx_stat_nxt[l].stat = STAT_NO_SRC;
        end
        else
        begin
          rx_stat_nxt[l].stat =
            rx_ovh_in[l].stat[STAT_HI:STAT_LO];
          rx_stat_nxt[l].iae = (l != LVL_PM) &&
            (rx_ovh_in[l].stat[STAT_HI:STAT_LO] == STAT_IAE);
        end
        rx_stat_nxt[l].stat_rsvd = stat_reserved(LVL_W'(l),
          rx_ovh_in[l].stat[STAT_HI:STAT_LO]);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_stat_r <= '0;
      err_cnt_r <= '0;
    end
    else
    begin
      rx_stat_r <= rx_stat_nxt;
      err_cnt_r <= err_cnt_nxt;
    end
  end
  assign rx_stat_out = rx_stat_r;
  assign rx_err_cnt_out = err_cnt_r;

  // source: build the outgoing overhead of the frame now starting
  ovh_s [NUM_LVL-1:0] tx_ovh_r;
  ovh_s [NUM_LVL-1:0] tx_ovh_nxt;

  always_comb
  begin
    tx_ovh_nxt = tx_ovh_r;
    if (frame_start_in)
    begin
      for (int l = 0; l < NUM_LVL; l++)
      begin
        tx_ovh_nxt[l].tti = tx_tti_q[l];
        tx_ovh_nxt[l].bip = tx_bip_calc_in[l];
        // errors found this frame go back in the overhead built at this same frame start
        if (l != LVL_PM && rx_stat_nxt[l].iae)
          tx_ovh_nxt[l].stat[BEI_HI:BEI_LO] = BIAE_CODE;
        else
          tx_ovh_nxt[l].stat[BEI_HI:BEI_LO] =
            err_cnt_nxt[l];
        tx_ovh_nxt[l].stat[BDI_BIT] = tx_sf_in[l];
        if (l == LVL_SM)
        begin
          tx_ovh_nxt[l].stat[IAE_BIT] = tx_iae_in;
          tx_ovh_nxt[l].stat[1:0] = SM_RES_VAL;
        end
        else
          tx_ovh_nxt[l].stat[STAT_HI:STAT_LO] =
            tx_stat_in[l];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tx_ovh_r <= '0;
    else
      tx_ovh_r <= tx_ovh_nxt;
  end
  assign tx_ovh_out = tx_ovh_r;

  // fault type and location message, one byte per frame
  logic [7:0] tx_ftfl_r;
  logic [7:0] tx_ftfl_nxt;
  logic [6:0] ftfl_pos;
  logic [6:0] opid_idx;

  assign ftfl_pos = mfas_nxt[6:0];
  assign opid_idx = ftfl_pos - FTFL_OPID_OFS;

  always_comb
  begin
    tx_ftfl_nxt = tx_ftfl_r;
    if (frame_start_in)
    begin
      // upper half of the multiframe carries the backward field
      if (ftfl_pos == FTFL_FIF_OFS)
        tx_ftfl_nxt = mfas_nxt[7] ? fault_byte(tx_bwd_fault_in) :
                      fault_byte(tx_fwd_fault_in);
      else if (ftfl_pos >= FTFL_OPID_OFS &&
               opid_idx < 7'(FTFL_OPID_LEN))
        tx_ftfl_nxt = tx_opid_in[opid_idx[3:0]];
      else
        tx_ftfl_nxt = 8'h00;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tx_ftfl_r <= FIF_NONE;
    else
      tx_ftfl_r <= tx_ftfl_nxt;
  end
  assign tx_ftfl_out = tx_ftfl_r;

  // receive fault indication bytes of both fields
  logic [7:0] rx_fwd_r;
  logic [7:0] rx_fwd_nxt;
  logic [7:0] rx_bwd_r;
  logic [7:0] rx_bwd_nxt;
  logic [1:0] fif_rsvd_r;
  logic [1:0] fif_rsvd_nxt;
  logic rx_fif_slot;

  assign rx_fif_slot = frame_start_in &&
                       (rx_mfas_in[6:0] == FTFL_FIF_OFS);

  always_comb
  begin
    rx_fwd_nxt = rx_fwd_r;
    rx_bwd_nxt = rx_bwd_r;
    fif_rsvd_nxt = fif_rsvd_r;
    if (rx_fif_slot && !rx_mfas_in[7])
    begin
      rx_fwd_nxt = rx_ftfl_in;
      fif_rsvd_nxt[0] = (rx_ftfl_in > FIF_SD);
    end
    if (rx_fif_slot && rx_mfas_in[7])
    begin
      rx_bwd_nxt = rx_ftfl_in;
      fif_rsvd_nxt[1] = (rx_ftfl_in > FIF_SD);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_fwd_r <= FIF_NONE;
      rx_bwd_r <= FIF_NONE;
      fif_rsvd_r <= 2'h0;
    end
    else
    begin
      rx_fwd_r <= rx_fwd_nxt;
      rx_bwd_r <= rx_bwd_nxt;
      fif_rsvd_r <= fif_rsvd_nxt;
    end
  end
  assign rx_fwd_fif_out = rx_fwd_r;
  assign rx_bwd_fif_out = rx_bwd_r;
  assign rx_fif_rsvd_out = fif_rsvd_r;
endmodule : otn_path_monitor_overhead
`default_nettype wire

// File: verif/ovh_mon_checker.sv
// port assertions for the overhead monitor
`timescale 1ns/100ps
`default_nettype none
module ovh_mon_checker
  import ovh_mon_pkg::*;
(
  input wire logic core_clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic frame_start_in, // frame pulse
  input wire ovh_s [NUM_LVL-1:0] rx_ovh_in, // rx overhead
  input wire logic [NUM_LVL-1:0][7:0] rx_bip_calc_in, // rx parity
  input wire logic [NUM_LVL-1:0][7:0] tx_bip_calc_in, // tx parity
  input wire logic [NUM_LVL-1:0] tx_sf_in, // defect to send
  input wire logic tx_iae_in, // iae to send
  input wire logic [NUM_LVL-1:0][2:0] tx_stat_in, // status to send
  input wire fault_e tx_fwd_fault_in, // fwd fault
  input wire fault_e tx_bwd_fault_in, // bwd fault
  input wire logic [7:0] mfas_out, // frame count
  input wire ovh_s [NUM_LVL-1:0] tx_ovh_out, // tx overhead
  input wire logic [7:0] tx_ftfl_out, // tx fault byte
  input wire rx_stat_s [NUM_LVL-1:0] rx_stat_out, // rx status
  input wire logic [NUM_LVL-1:0][3:0] rx_err_cnt_out // rx errors
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [NUM_LVL-1:0] bdi_sent;
  always_comb
  begin
    for (int i = 0; i < NUM_LVL; i++)
    begin
      bdi_sent[i] = tx_ovh_out[i].stat[BDI_BIT];
    end
  end
  chk_mfas_step: assert property (
    frame_start_in |=> mfas_out == $past(mfas_out) + 8'h01)
    else $error("frame count did not step");
  chk_mfas_hold: assert property (
    !frame_start_in |=> $stable(mfas_out))
    else $error("frame count moved");
  chk_bdi_sent: assert property (
    frame_start_in |=> bdi_sent == $past(tx_sf_in))
    else $error("defect bits wrong");
  chk_sm_byte: assert property (
    frame_start_in |=>
    tx_ovh_out[0].stat[2:0] == {$past(tx_iae_in), SM_RES_VAL})
    else $error("section status bits wrong");
  chk_stat_sent: assert property (
    frame_start_in |=> tx_ovh_out[7].stat[2:0] == $past(tx_stat_in[7])
    && tx_ovh_out[3].stat[2:0] == $past(tx_stat_in[3]))
    else $error("status field wrong");
  chk_bip_sent: assert property (
    frame_start_in |=> tx_ovh_out[5].bip == $past(tx_bip_calc_in[5]))
    else $error("parity byte wrong");
  chk_pm_bei: assert property (
    frame_start_in |=> rx_err_cnt_out[7] ==
    $countones($past(rx_ovh_in[7].bip) ^ $past(rx_bip_calc_in[7]))
    && tx_ovh_out[7].stat[7:4] == rx_err_cnt_out[7])
    else $error("path error count wrong");
  chk_tcm_biae: assert property (
    frame_start_in && rx_ovh_in[2].stat[2:0] == STAT_IAE
    |=> tx_ovh_out[2].stat[7:4] == BIAE_CODE)
    else $error("alignment code not sent");
  chk_rx_bei: assert property (
    frame_start_in |=> rx_stat_out[1].bei ==
    ($past(rx_ovh_in[1].stat[7:4]) > BEI_MAX ? 4'h0
    : $past(rx_ovh_in[1].stat[7:4])))
    else $error("error count decode wrong");
  chk_fault_byte: assert property (
    frame_start_in ##1 mfas_out[6:0] == 7'h00 |-> tx_ftfl_out ==
    {6'h00, mfas_out[7] ? $past(tx_bwd_fault_in) : $past(tx_fwd_fault_in)})
    else $error("fault byte wrong");
  cov_wrap: cover property (frame_start_in && mfas_out == MFAS_MAX);
  cov_biae: cover property (tx_ovh_out[1].stat[7:4] == BIAE_CODE);
  cov_bwd: cover property (frame_start_in ##1 mfas_out == 8'h80);
endmodule : ovh_mon_checker
bind otn_path_monitor_overhead ovh_mon_checker u_ovh_mon_checker (.*);
`default_nettype wire

// File: verif/remote_otn_model.sv
// far-end equipment: sends overhead, trace and fault bytes
`timescale 1ns/100ps
`default_nettype none
module remote_otn_model
  import ovh_mon_pkg::*;
(
  input wire logic core_clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic frame_start_in, // frame pulse
  input wire logic [7:0] fwd_code_in, // fwd fault byte
  input wire logic [7:0] bwd_code_in, // bwd fault byte
  output logic [7:0] mfas_out, // multiframe byte
  output var ovh_s [NUM_LVL-1:0] ovh_out, // overhead per level
  output logic [7:0] ftfl_out // fault message byte
);
  logic [7:0] mf_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      mf_r <= 8'h00;
    else if (frame_start_in)
      mf_r <= mf_r + 8'h01;
  end
  always_comb
  begin
    mfas_out = mf_r;
    for (int l = 0; l < NUM_LVL; l++)
    begin
      ovh_out[l].tti = 8'(l * 19) + {2'h0, mf_r[5:0]} + 8'h80;
      ovh_out[l].bip = 8'hff >> (4'h8 - 4'(mf_r % 9));
      ovh_out[l].stat = {mf_r[3:0], mf_r[7], mf_r[6:4]};
    end
    if (mf_r[6:0] == 7'h00)
      ftfl_out = mf_r[7] ? bwd_code_in : fwd_code_in;
    else
      ftfl_out = ~mf_r;
  end
endmodule : remote_otn_model
`default_nettype wire

// File: verif/otn_path_monitor_overhead_test.sv
// self-checking bench for the overhead monitor
`timescale 1ns/100ps
`default_nettype none
module otn_path_monitor_overhead_test
  import ovh_mon_pkg::*;
;
  logic core_clk_in, rst_n_in, frame_start_in, tti_wr_en_in, tx_iae_in;
  logic [7:0] rx_mfas_in, rx_ftfl_in, tti_wr_data_in, mfas_out, tx_ftfl_out;
  logic [7:0] rx_fwd_fif_out, rx_bwd_fif_out, fwd_code, bwd_code, ef, eb;
  ovh_s [NUM_LVL-1:0] rx_ovh_in, tx_ovh_out;
  logic [NUM_LVL-1:0][7:0] rx_bip_calc_in, tx_bip_calc_in, rx_tti_out;
  logic [NUM_LVL-1:0] tx_sf_in;
  logic [NUM_LVL-1:0][2:0] tx_stat_in;
  fault_e tx_fwd_fault_in, tx_bwd_fault_in;
  logic [FTFL_OPID_LEN-1:0][7:0] tx_opid_in;
  logic [LVL_W-1:0] tti_wr_lvl_in;
  logic [TTI_AW-1:0] tti_wr_addr_in, tti_rd_addr_in;
  rx_stat_s [NUM_LVL-1:0] rx_stat_out;
  logic [NUM_LVL-1:0][3:0] rx_err_cnt_out;
  logic [1:0] rx_fif_rsvd_out;
  int errors, comparisons, cycles;
  otn_path_monitor_overhead u_otn_path_monitor_overhead (.*);
  remote_otn_model u_remote_otn_model (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .frame_start_in(frame_start_in),
    .fwd_code_in(fwd_code), .bwd_code_in(bwd_code), .mfas_out(rx_mfas_in),
    .ovh_out(rx_ovh_in), .ftfl_out(rx_ftfl_in));
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  task automatic tally_and_finish;
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [7:0] exp_ftfl(input logic [7:0] m, input int n);
    if (m[6:0] == 7'h00)
      return m[7] ? 8'h02 : (n < 256 ? 8'h01 : 8'h00);
    if (m[6:0] <= 7'h09)
      return 8'h40 + {1'b0, m[6:0]};
    return 8'h00;
  endfunction : exp_ftfl
  task automatic frame(input int n);
    logic [7:0] m;
    logic [3:0] cnt;
    logic [3:0] nib;
    logic [2:0] s;
    m = n[7:0];
    nib = m[3:0];
    s = m[6:4];
    cnt = 4'($countones((8'hff >> (8 - m % 9)) ^ 8'hf0));
    @(posedge core_clk_in);
    frame_start_in <= 1'b1;
    tx_sf_in <= 8'(n * 3);
    tx_iae_in <= n[1];
    for (int l = 0; l < NUM_LVL; l++)
      tx_stat_in[l] <= 3'(n + l);
    tx_bip_calc_in <= {NUM_LVL{m}};
    tx_fwd_fault_in <= n < 256 ? FAULT_SF : FAULT_NONE;
    if (m[6:0] == 7'h00)
    begin
      if (m[7])
        eb = bwd_code;
      else
        ef = fwd_code;
    end
    @(posedge core_clk_in);
    frame_start_in <= 1'b0;
    #1;
    cmp(mfas_out, m);
    for (int l = 0; l < NUM_LVL; l++)
      cmp(tx_ovh_out[l].tti, 8'(l * 37) ^ {2'h0, m[5:0]});
    cmp(tx_ovh_out[7].stat, {cnt, tx_sf_in[7], tx_stat_in[7]});
    cmp(tx_ovh_out[1].stat, {s == 3'h2 ? BIAE_CODE : cnt, tx_sf_in[1],
      tx_stat_in[1]});
    cmp(tx_ovh_out[0].stat, {m[6] ? BIAE_CODE : cnt, tx_sf_in[0], tx_iae_in,
      SM_RES_VAL});
    cmp(tx_ovh_out[5].bip, tx_bip_calc_in[5]);
    cmp(rx_err_cnt_out[7], cnt);
    cmp({rx_stat_out[1].bei, rx_stat_out[1].biae, rx_stat_out[1].bdi,
      rx_stat_out[1].stat, rx_stat_out[1].stat_rsvd}, {nib > 4'h8 ? 4'h0 : nib,
      nib == 4'hb, m[7], s, s inside {3'h3, 3'h4}});
    cmp({rx_stat_out[7].bei, rx_stat_out[7].biae, rx_stat_out[7].stat_rsvd},
      {nib > 4'h8 ? 4'h0 : nib, 1'b0,
      !(s inside {3'h1, 3'h5, 3'h6, 3'h7})});
    cmp({rx_stat_out[0].biae, rx_stat_out[0].iae},
      {nib == 4'hb, m[6]});
    cmp(tx_ftfl_out, exp_ftfl(m, n));
    cmp({rx_fwd_fif_out, rx_bwd_fif_out}, {ef, eb});
    cmp(rx_fif_rsvd_out, {eb > 8'h02, ef > 8'h02});
    @(posedge core_clk_in);
  endtask : frame
  initial
  begin
    errors = 0;
    comparisons = 0;
    cycles = 0;
    rst_n_in = 1'b0;
    frame_start_in = 1'b0;
    tti_wr_en_in = 1'b0;
    tti_wr_lvl_in = '0;
    tti_wr_addr_in = '0;
    tti_wr_data_in = '0;
    tti_rd_addr_in = '0;
    rx_bip_calc_in = {NUM_LVL{8'hf0}};
    tx_bip_calc_in = '0;
    tx_sf_in = '0;
    tx_iae_in = 1'b0;
    tx_stat_in = '0;
    tx_fwd_fault_in = FAULT_SF;
    tx_bwd_fault_in = FAULT_SD;
    fwd_code = 8'h01;
    bwd_code = 8'h07;
    ef = 8'h00;
    eb = 8'h00;
    for (int k = 0; k < FTFL_OPID_LEN; k++)
      tx_opid_in[k] = 8'h41 + 8'(k);
    repeat (3) @(posedge core_clk_in);
    cmp({mfas_out, tx_ftfl_out}, {MFAS_RST, 8'h00});
    rst_n_in <= 1'b1;
    for (int l = 0; l < NUM_LVL; l++)
      for (int a = 0; a < TTI_LEN; a++)
      begin
        @(posedge core_clk_in);
        tti_wr_en_in <= 1'b1;
        tti_wr_lvl_in <= 3'(l);
        tti_wr_addr_in <= 6'(a);
        tti_wr_data_in <= 8'(l * 37) ^ 8'(a);
      end
    @(posedge core_clk_in);
    tti_wr_en_in <= 1'b0;
    for (int n = 0; n < 260; n++)
      frame(n);
    for (int a = 0; a < TTI_LEN; a++)
    begin
      @(posedge core_clk_in);
      tti_rd_addr_in <= 6'(a);
      @(posedge core_clk_in);
      #1;
      cmp({rx_tti_out[0], rx_tti_out[7]},
        {8'(a) + 8'h80, 8'(133 + a) + 8'h80});
    end
    tally_and_finish();
  end
endmodule : otn_path_monitor_overhead_test
`default_nettype wire
